// ==== design/ptsa_consts.svh ====
`ifndef PTSA_CONSTS_SVH
`define PTSA_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register dword offsets
// ----------------------------------------------------------------------------
`define PTSA_OFS_TX_PERIOD 8'hd0
`define PTSA_OFS_TX_FRAC 8'hd1
`define PTSA_OFS_TX_WHOLE 8'hd2
`define PTSA_OFS_RX_PERIOD 8'hd3
`define PTSA_OFS_RX_FRAC 8'hd4
`define PTSA_OFS_RX_WHOLE 8'hd5

// ----------------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------------
`define PTSA_ADDR_W 8
`define PTSA_DATA_W 32
`define PTSA_FRAC_W 16
`define PTSA_PERIOD_WHOLE_W 9
`define PTSA_PERIOD_W 25
`define PTSA_ADJ_W 16
`define PTSA_STAMP_NS_W 48
`define PTSA_STAGE_W 8
`define PTSA_PERIOD_RESET 25'h0000000
`define PTSA_ADJ_RESET 16'h0000

`endif

// ==== design/ptsa_pkg.sv ====
`include "ptsa_consts.svh"
`default_nettype none

package ptsa_pkg;

  // Timestamp as fixed point: whole nanoseconds above a 16-bit fraction.
  typedef struct packed {
    logic [`PTSA_STAMP_NS_W-1:0] ns;
    logic [`PTSA_FRAC_W-1:0] fns;
  } ptsa_stamp_t;

  typedef struct packed {
    logic [`PTSA_PERIOD_W-1:0] period;
    logic [`PTSA_ADJ_W-1:0] adjWhole;
    logic [`PTSA_ADJ_W-1:0] adjFrac;
  } ptsa_path_cfg_t;

  typedef struct packed {
    logic valid;
    ptsa_stamp_t stamp;
  } ptsa_stamp_beat_t;

endpackage : ptsa_pkg

`default_nettype wire

// ==== design/ptsa_stamp_correct.sv ====
`include "ptsa_consts.svh"
`default_nettype none

module ptsa_stamp_correct (
  input wire logic mclk,
  input wire logic reset,
  input wire ptsa_pkg::ptsa_path_cfg_t cfg,
  input wire logic [`PTSA_STAGE_W-1:0] stageCount,
  input wire ptsa_pkg::ptsa_stamp_beat_t inBeat,
  output ptsa_pkg::ptsa_stamp_beat_t outBeat
);
  import ptsa_pkg::*;

  localparam int STAMP_W = `PTSA_STAMP_NS_W + `PTSA_FRAC_W;
  localparam int PROD_W = `PTSA_PERIOD_W + `PTSA_STAGE_W;

  ptsa_stamp_beat_t state_ff;
  ptsa_stamp_beat_t nxt_state;

  // Period times stages, laid out on the same binary point as the stamp.
  function automatic logic [STAMP_W-1:0] periodCorr(input logic [`PTSA_PERIOD_W-1:0] period,
                                                   input logic [`PTSA_STAGE_W-1:0] stages);
    logic [PROD_W-1:0] prod;
    prod = period * stages;
    periodCorr = {{(STAMP_W-PROD_W){1'b0}}, prod};
  endfunction : periodCorr

  always_comb begin
    logic [STAMP_W-1:0] staticCorr;
    staticCorr = {{(STAMP_W-2*`PTSA_ADJ_W){1'b0}}, cfg.adjWhole, cfg.adjFrac};
    nxt_state.valid = inBeat.valid;
    nxt_state.stamp = state_ff.stamp;
    if (inBeat.valid) begin
      // One wide add keeps the fraction carry into ns without extra logic; wraps modulo the stamp width.
      nxt_state.stamp = STAMP_W'(inBeat.stamp + periodCorr(cfg.period, stageCount) + staticCorr);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign outBeat = state_ff;

endmodule : ptsa_stamp_correct

`default_nettype wire

// ==== design/ptsa_delay_adjust_regs.sv ====
`include "ptsa_consts.svh"
`default_nettype none

module ptsa_delay_adjust_regs (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [`PTSA_ADDR_W-1:0] ctlAddr,
  input wire logic ctlRead,
  input wire logic ctlWrite,
  input wire logic [`PTSA_DATA_W-1:0] ctlWriteData,
  output logic [`PTSA_DATA_W-1:0] ctlReadData,
  output logic ctlReadValid,
  input wire ptsa_pkg::ptsa_stamp_beat_t txStampIn,
  input wire logic [`PTSA_STAGE_W-1:0] txStageCount,
  output ptsa_pkg::ptsa_stamp_beat_t txStampOut,
  input wire ptsa_pkg::ptsa_stamp_beat_t rxStampIn,
  input wire logic [`PTSA_STAGE_W-1:0] rxStageCount,
  output ptsa_pkg::ptsa_stamp_beat_t rxStampOut
);
  import ptsa_pkg::*;

  typedef struct packed {
    ptsa_path_cfg_t tx;
    ptsa_path_cfg_t rx;
    logic [`PTSA_DATA_W-1:0] readData;
    logic readValid;
  } ptsa_regs_state_t;

  ptsa_regs_state_t state_ff;
  ptsa_regs_state_t nxt_state;

  // ----------------------------------------------------------------------------
  // Field packing helpers
  // ----------------------------------------------------------------------------
  // Only the defined bits are stored, so unused bits always read back as zero.
  function automatic logic [`PTSA_DATA_W-1:0] padWord(input logic [`PTSA_PERIOD_W-1:0] value);
    padWord = {{(`PTSA_DATA_W-`PTSA_PERIOD_W){1'b0}}, value};
  endfunction : padWord

  function automatic logic [`PTSA_PERIOD_W-1:0] periodField(input logic [`PTSA_DATA_W-1:0] word);
    periodField = word[`PTSA_PERIOD_W-1:0];
  endfunction : periodField

  function automatic logic [`PTSA_ADJ_W-1:0] adjField(input logic [`PTSA_DATA_W-1:0] word);
    adjField = word[`PTSA_ADJ_W-1:0];
  endfunction : adjField

  // ----------------------------------------------------------------------------
  // Register writes and reads
  // ----------------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_state.readValid = ctlRead;
    if (ctlWrite) begin
      unique case (ctlAddr)
        `PTSA_OFS_TX_PERIOD: nxt_state.tx.period = periodField(ctlWriteData);
        `PTSA_OFS_TX_FRAC: nxt_state.tx.adjFrac = adjField(ctlWriteData);
        `PTSA_OFS_TX_WHOLE: nxt_state.tx.adjWhole = adjField(ctlWriteData);
        `PTSA_OFS_RX_PERIOD: nxt_state.rx.period = periodField(ctlWriteData);
        `PTSA_OFS_RX_FRAC: nxt_state.rx.adjFrac = adjField(ctlWriteData);
        `PTSA_OFS_RX_WHOLE: nxt_state.rx.adjWhole = adjField(ctlWriteData);
        default: ;
      endcase
    end
    if (ctlRead) begin
      // A read in the same cycle as a write returns the value from before the write.
      unique case (ctlAddr)
        `PTSA_OFS_TX_PERIOD: nxt_state.readData = padWord(state_ff.tx.period);
        `PTSA_OFS_TX_FRAC: nxt_state.readData = padWord(25'(state_ff.tx.adjFrac));
        `PTSA_OFS_TX_WHOLE: nxt_state.readData = padWord(25'(state_ff.tx.adjWhole));
        `PTSA_OFS_RX_PERIOD: nxt_state.readData = padWord(state_ff.rx.period);
        `PTSA_OFS_RX_FRAC: nxt_state.readData = padWord(25'(state_ff.rx.adjFrac));
        `PTSA_OFS_RX_WHOLE: nxt_state.readData = padWord(25'(state_ff.rx.adjWhole));
        default: nxt_state.readData = '0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff.tx.period <= `PTSA_PERIOD_RESET;
      state_ff.tx.adjWhole <= `PTSA_ADJ_RESET;
      state_ff.tx.adjFrac <= `PTSA_ADJ_RESET;
      state_ff.rx.period <= `PTSA_PERIOD_RESET;
      state_ff.rx.adjWhole <= `PTSA_ADJ_RESET;
      state_ff.rx.adjFrac <= `PTSA_ADJ_RESET;
      state_ff.readData <= '0;
      state_ff.readValid <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign ctlReadData = state_ff.readData;
  assign ctlReadValid = state_ff.readValid;

  // ----------------------------------------------------------------------------
  // Timestamp correction per datapath
  // ----------------------------------------------------------------------------
  // The stage count and stamps come from MAC logic on mclk, so no synchroniser is needed.
  ptsa_stamp_correct txCorrect (
    .mclk(mclk),
    .reset(reset),
    .cfg(state_ff.tx),
    .stageCount(txStageCount),
    .inBeat(txStampIn),
    .outBeat(txStampOut)
  );

  ptsa_stamp_correct rxCorrect (
    .mclk(mclk),
    .reset(reset),
    .cfg(state_ff.rx),
    .stageCount(rxStageCount),
    .inBeat(rxStampIn),
    .outBeat(rxStampOut)
  );

endmodule : ptsa_delay_adjust_regs

`default_nettype wire

// ==== tb/ptsa_regs_props.sv ====
`include "ptsa_consts.svh"
`default_nettype none

module ptsa_regs_props (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [`PTSA_ADDR_W-1:0] ctlAddr,
  input wire logic ctlRead,
  input wire logic [`PTSA_DATA_W-1:0] ctlReadData,
  input wire logic ctlReadValid,
  input wire ptsa_pkg::ptsa_stamp_beat_t txStampIn,
  input wire ptsa_pkg::ptsa_stamp_beat_t txStampOut,
  input wire ptsa_pkg::ptsa_stamp_beat_t rxStampIn,
  input wire ptsa_pkg::ptsa_stamp_beat_t rxStampOut
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_rdReq; ctlRead; endsequence
  property p_rdv; s_rdReq |=> ctlReadValid; endproperty
  a_rdv: assert property (p_rdv) else $error("read not answered");
  property p_rdq; !ctlRead |=> !ctlReadValid && $stable(ctlReadData); endproperty
  a_rdq: assert property (p_rdq) else $error("read answer without request");
  property p_unm; ctlRead && (ctlAddr < 8'hd0 || ctlAddr > 8'hd5) |=> ctlReadData == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_per; ctlRead && (ctlAddr == 8'hd0 || ctlAddr == 8'hd3) |=> ctlReadData[31:25] == 7'h0; endproperty
  a_per: assert property (p_per) else $error("period spare bits set");
  property p_adj; ctlRead && ctlAddr inside {8'hd1, 8'hd2, 8'hd4, 8'hd5} |=> ctlReadData[31:16] == 16'h0; endproperty
  a_adj: assert property (p_adj) else $error("correction spare bits set");
  property p_txv; txStampIn.valid |=> txStampOut.valid; endproperty
  a_txv: assert property (p_txv) else $error("tx stamp lost");
  property p_rxv; rxStampIn.valid |=> rxStampOut.valid; endproperty
  a_rxv: assert property (p_rxv) else $error("rx stamp lost");
  property p_txh; !txStampIn.valid |=> !txStampOut.valid && $stable(txStampOut.stamp); endproperty
  a_txh: assert property (p_txh) else $error("tx stamp moved unasked");
  property p_rxh; !rxStampIn.valid |=> !rxStampOut.valid && $stable(rxStampOut.stamp); endproperty
  a_rxh: assert property (p_rxh) else $error("rx stamp moved unasked");
endmodule : ptsa_regs_props

bind ptsa_delay_adjust_regs ptsa_regs_props chk_u (.mclk, .reset, .ctlAddr, .ctlRead, .ctlReadData,
  .ctlReadValid, .txStampIn, .txStampOut, .rxStampIn, .rxStampOut);

`default_nettype wire

// ==== tb/ptsa_mac_stamp_src.sv ====
`default_nettype none

module ptsa_mac_stamp_src (
  input wire logic mclk,
  input wire logic fire,
  input wire ptsa_pkg::ptsa_stamp_t stamp,
  output ptsa_pkg::ptsa_stamp_beat_t beat
);
  import ptsa_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // Off the valid pulse the stamp is inverted, so a design that samples it late is caught.
  always_ff @(posedge mclk) begin
    beat.valid <= fire;
    beat.stamp <= fire ? stamp : ~beat.stamp;
  end
endmodule : ptsa_mac_stamp_src

`default_nettype wire

// ==== tb/ptsa_delay_adjust_regs_test.sv ====
`default_nettype none

module ptsa_delay_adjust_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ptsa_pkg::*;
  logic mclk = 1'b0, reset = 1'b1, ctlRead = 1'b0, ctlWrite = 1'b0, txFire = 1'b0, rxFire = 1'b0;
  logic [7:0] ctlAddr = 8'h0, txStageCount = 8'h0, rxStageCount = 8'h0;
  logic [31:0] ctlWriteData = 32'h0, ctlReadData;
  logic ctlReadValid;
  ptsa_stamp_t txSt = 64'h0, rxSt = 64'h0;
  ptsa_stamp_beat_t txStampIn, rxStampIn, txStampOut, rxStampOut;
  int num_errors = 0, samples_checked = 0, cycles = 0;

  always #4 mclk = ~mclk;

  ptsa_delay_adjust_regs dut_u (.mclk, .reset, .ctlAddr, .ctlRead, .ctlWrite, .ctlWriteData, .ctlReadData,
    .ctlReadValid, .txStampIn, .txStageCount, .txStampOut, .rxStampIn, .rxStageCount, .rxStampOut);
  ptsa_mac_stamp_src tx_src_u (.mclk(mclk), .fire(txFire), .stamp(txSt), .beat(txStampIn));
  ptsa_mac_stamp_src rx_src_u (.mclk(mclk), .fire(rxFire), .stamp(rxSt), .beat(rxStampIn));

  task automatic test_done();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // A hung handshake would otherwise stall the run forever.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 1000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic cmp(input string n, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ctlAddr <= a;
    ctlWriteData <= d;
    ctlWrite <= 1'b1;
    @(posedge mclk);
    ctlWrite <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    ctlAddr <= a;
    ctlRead <= 1'b1;
    @(posedge mclk);
    ctlRead <= 1'b0;
    #1;
    cmp("readValid", 64'h1, {63'h0, ctlReadValid});
    cmp("readData", {32'h0, e}, {32'h0, ctlReadData});
    @(posedge mclk);
  endtask : rd

  task automatic stamps(input ptsa_stamp_t ts, input ptsa_stamp_t te, input ptsa_stamp_t rs, input ptsa_stamp_t re);
    txSt <= ts;
    rxSt <= rs;
    txFire <= 1'b1;
    rxFire <= 1'b1;
    @(posedge mclk);
    txFire <= 1'b0;
    rxFire <= 1'b0;
    @(posedge mclk);
    #1;
    cmp("stampValid", 64'h3, {62'h0, txStampOut.valid, rxStampOut.valid});
    cmp("txStamp", te, txStampOut.stamp);
    cmp("rxStamp", re, rxStampOut.stamp);
    @(posedge mclk);
  endtask : stamps

  initial begin
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    for (logic [7:0] a = 8'hd0; a < 8'hd7; a++) rd(a, 32'h0);
    for (logic [7:0] a = 8'hd0; a < 8'hd7; a++) wr(a, 32'hffffffff);
    for (logic [7:0] a = 8'hd0; a < 8'hd7; a++) begin
      rd(a, (a == 8'hd6) ? 32'h0 : (a == 8'hd0 || a == 8'hd3) ? 32'h01ffffff : 32'h0000ffff);
    end
    wr(8'hd0, 32'hfe080000);
    wr(8'hd1, 32'h00008000);
    wr(8'hd2, 32'h00000003);
    wr(8'hd3, 32'h00018000);
    wr(8'hd4, 32'h00000001);
    wr(8'hd5, 32'hffffffff);
    rd(8'hd0, 32'h00080000);
    txStageCount <= 8'h02;
    rxStageCount <= 8'h03;
    stamps({48'h64, 16'hc000}, {48'h78, 16'h4000}, {48'h3e8, 16'hffff}, {48'h103ec, 16'h8000});
    test_done();
  end
endmodule : ptsa_delay_adjust_regs_test

`default_nettype wire
